// File: rtl/epa_pkg.sv
// Summary of operation
// - advertisement register answers at byte offset 1d0 as a 32-bit word
// - loader rewrites every advertisement field after reset release and on reload
// - bits 31-16 read zero; serial access moves only 16 bits
// - next-page advertisement bit 15 always reads zero
// - remote fault bit 13 reads zero; bits 14 and 12 reserved, zero
// - asymmetric pause bit 11 writable, resets to zero
// - pause bit 10 writable, resets to inverse of strap
// - flow-control strap captured when chip reset deasserts
// - 100BASE-T4 bit 9 always reads zero
// - 100 Mb/s full and half duplex bits 8,7 writable, reset one
// - 10 Mb/s full and half duplex bits 6,5 writable, reset one
// - selector bits 4:0 writable, reset 00001; software writes only that code
// - partner ability register at 1d4, 32 bits, read-only
// - partner ability contents built internally, not from a cable
// - partner next-page bit 15 always reads zero
// - partner acknowledge bit 14 always reads one
package epa_pkg;
  localparam logic [11:0] EPA_ADV_OFFSET = 12'h1d0;
  localparam logic [11:0] EPA_LP_OFFSET = 12'h1d4;
  localparam logic [4:0] EPA_ADV_INDEX = 5'h04;
  localparam logic [4:0] EPA_LP_INDEX = 5'h05;
  localparam logic [4:0] EPA_SELECTOR_RST = 5'h01;
  localparam int EPA_BIT_ACK = 14;
  localparam int EPA_BIT_ASYM = 11;
  localparam int EPA_BIT_PAUSE = 10;

  // writable part of the advertisement register
  typedef struct packed {
    logic asym_pause;
    logic pause;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
    logic [4:0] selector;
  } epa_adv_s;

  // value held while reset is asserted, before the loader rewrites it
  localparam epa_adv_s EPA_ADV_RST = '{asym_pause: 1'b0, pause: 1'b1, fd100: 1'b1, hd100: 1'b1,
                                       fd10: 1'b1, hd10: 1'b1, selector: EPA_SELECTOR_RST};

  // register access request, memory-mapped or serial
  typedef struct packed {
    logic wr;
    logic rd;
    logic serial;
    logic [11:0] addr;
    logic [31:0] wdata;
  } epa_req_s;
endpackage

// File: rtl/epa_strap_latch.sv
`timescale 1ns/1ps
// ==========================================
// strap synchroniser and capture at reset release
module epa_strap_latch (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic strap_i,
  output logic strap_o,
  output logic release_o
);
  import epa_pkg::*;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic rst_d_reg;
  logic rst_d_next;
  logic strap_reg;
  logic strap_next;
  logic stable;

  always_comb begin
    sync_next = {sync_reg[1:0], strap_i};
    rst_d_next = 1'b0;
    // second and third stages agree: the level is trusted
    stable = (sync_reg[2] == sync_reg[1]);
    strap_next = strap_reg;
    if (rst_d_reg && stable) begin
      strap_next = sync_reg[1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    sync_reg <= sync_next;
    if (sys_rst_i) begin
      rst_d_reg <= 1'b1;
      strap_reg <= 1'b0;
    end else begin
      rst_d_reg <= rst_d_next;
      strap_reg <= strap_next;
    end
  end

  assign strap_o = (rst_d_reg && stable) ? sync_reg[1] : strap_reg;
  assign release_o = rst_d_reg && !sys_rst_i;
endmodule

// File: rtl/epa_regs.sv
`timescale 1ns/1ps
// ==========================================
// advertisement and emulated partner ability registers
module epa_regs (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic flow_ctrl_default_strap_i,
  input wire logic reload_i,
  input epa_pkg::epa_req_s req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic addr_err_o,
  output epa_pkg::epa_adv_s adv_o
);
  import epa_pkg::*;

  logic strap;
  logic release_pulse;
  epa_adv_s adv_reg;
  epa_adv_s adv_next;
  epa_adv_s adv_load;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic err_reg;
  logic err_next;
  logic [15:0] adv_word;
  logic [15:0] lp_word;
  logic hit_adv;
  logic hit_lp;

  epa_strap_latch u_strap (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .strap_i(flow_ctrl_default_strap_i),
    .strap_o(strap),
    .release_o(release_pulse)
  );

  // ==========================================
  // loader image and register update
  always_comb begin
    adv_load.asym_pause = 1'b0;
    adv_load.pause = ~strap;
    adv_load.fd100 = 1'b1;
    adv_load.hd100 = 1'b1;
    adv_load.fd10 = 1'b1;
    adv_load.hd10 = 1'b1;
    adv_load.selector = EPA_SELECTOR_RST;
  end

  always_comb begin
    if (req_i.serial) begin
      hit_adv = req_i.addr[4:0] == EPA_ADV_INDEX;
      hit_lp = req_i.addr[4:0] == EPA_LP_INDEX;
    end else begin
      hit_adv = req_i.addr == EPA_ADV_OFFSET;
      hit_lp = req_i.addr == EPA_LP_OFFSET;
    end
  end

  always_comb begin
    adv_next = adv_reg;
    // loader rewrite beats a software write in the same cycle
    if (release_pulse || reload_i) begin
      adv_next = adv_load;
    end else if (req_i.wr && hit_adv) begin
      adv_next.asym_pause = req_i.wdata[EPA_BIT_ASYM];
      adv_next.pause = req_i.wdata[EPA_BIT_PAUSE];
      adv_next.fd100 = req_i.wdata[8];
      adv_next.hd100 = req_i.wdata[7];
      adv_next.fd10 = req_i.wdata[6];
      adv_next.hd10 = req_i.wdata[5];
      adv_next.selector = req_i.wdata[4:0];
    end
  end

  // ==========================================
  // read path
  always_comb begin
    // bits 15,14,13,12,9 constant zero
    adv_word = {3'h0, 1'b0, adv_reg.asym_pause, adv_reg.pause, 1'b0, adv_reg.fd100, adv_reg.hd100,
                adv_reg.fd10, adv_reg.hd10, adv_reg.selector};
    // emulated partner: acks, no next page, mirrors our abilities
    lp_word = 16'h0000;
    lp_word[EPA_BIT_ACK] = 1'b1;
    lp_word[15] = 1'b0;
    lp_word[11:0] = adv_word[11:0];
    rdata_next = 32'h0000_0000;
    rvalid_next = req_i.rd;
    err_next = (req_i.rd || req_i.wr) && !hit_adv && !hit_lp;
    if (req_i.rd && hit_adv) begin
      rdata_next = {16'h0000, adv_word};
    end else if (req_i.rd && hit_lp) begin
      rdata_next = {16'h0000, lp_word};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      adv_reg <= EPA_ADV_RST;
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      adv_reg <= adv_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      err_reg <= err_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign addr_err_o = err_reg;
  assign adv_o = adv_reg;

  // ==========================================
  // checks
  a_upper_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rvalid_o |-> rdata_o[31:16] == 16'h0000) else $error("upper half not zero");
  a_adv_ro_bits: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(req_i.rd && hit_adv) |-> (rdata_o[15:12] == 4'h0 && rdata_o[9] == 1'b0))
    else $error("advertisement read-only bits nonzero");
  a_rf_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(req_i.rd && hit_adv) |-> !rdata_o[13]) else $error("remote fault not zero");
  a_reload_img: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    reload_i |=> (adv_o.fd100 && adv_o.hd100 && adv_o.fd10 && adv_o.hd10 && !adv_o.asym_pause))
    else $error("reload image wrong");
  a_reload_pause: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    reload_i |=> adv_o.pause == ~$past(strap)) else $error("pause default wrong");
  a_reload_sel: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    reload_i |=> adv_o.selector == 5'h01) else $error("selector default wrong");
  a_write_takes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (req_i.wr && hit_adv && !reload_i && !release_pulse) |=>
    adv_o.asym_pause == $past(req_i.wdata[11])) else $error("asym pause write lost");
  a_write_speed: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (req_i.wr && hit_adv && !reload_i && !release_pulse) |=>
    {adv_o.fd100, adv_o.hd100, adv_o.fd10, adv_o.hd10} == $past(req_i.wdata[8:5]))
    else $error("speed bits write lost");
  a_lp_fixed: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(req_i.rd && hit_lp) |-> (rdata_o[14] && !rdata_o[15])) else $error("partner ack/np wrong");
  a_lp_ro: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (req_i.wr && hit_lp && !reload_i && !release_pulse) |=> $stable(adv_o))
    else $error("partner write changed state");
  a_release_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    release_pulse |=> (adv_o.fd100 && adv_o.hd100 && adv_o.fd10 && adv_o.hd10 && !adv_o.asym_pause))
    else $error("release image wrong");
  a_release_pause: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    release_pulse |=> adv_o.pause == ~$past(strap)) else $error("release pause default wrong");
  a_lp_upper_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(req_i.rd && hit_lp) |-> rdata_o[31:16] == 16'h0000) else $error("partner upper half not zero");
endmodule

// File: dv/epa_host.sv
`timescale 1ns/1ps
// ==========================================
// management host: one-cycle request pulses
module epa_host (
  input wire logic sys_clk_i,
  input wire logic rvalid_i,
  input wire logic err_i,
  input wire logic [31:0] rdata_i,
  output epa_pkg::epa_req_s req_o
);
  import epa_pkg::*;
  logic [31:0] got;
  logic gv;
  logic ge;
  initial req_o = '0;
  // answer only stands one cycle, so sample right after the taking edge
  task automatic xfer(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req_o <= '{wr: w, rd: !w, serial: s, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req_o <= '0;
    #1;
    got = rdata_i;
    gv = rvalid_i;
    ge = err_i;
  endtask
endmodule

// File: dv/emulated_phy_autoneg_adv_regs_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module emulated_phy_autoneg_adv_regs_tb_top;
  import epa_pkg::*;
  logic sys_clk_i = 0;
  logic sys_rst_i = 1;
  logic strap = 0;
  logic reload = 0;
  epa_req_s req;
  logic [31:0] rdata;
  logic rvalid;
  logic aerr;
  epa_adv_s adv;
  int bad_count = 0;
  int total_checks = 0;
  logic [31:0] exp_adv;
  logic [15:0] lfsr = 16'h0006;
  always #10 sys_clk_i = ~sys_clk_i;
  epa_regs dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .flow_ctrl_default_strap_i(strap),
    .reload_i(reload), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .addr_err_o(aerr), .adv_o(adv));
  epa_host host (.sys_clk_i(sys_clk_i), .rvalid_i(rvalid), .err_i(aerr), .rdata_i(rdata), .req_o(req));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // reads both registers mapped and serial against the model
  task automatic rd_both();
    for (int s = 0; s < 2; s++) begin
      host.xfer(0, s[0], s ? 12'(EPA_ADV_INDEX) : EPA_ADV_OFFSET, 0);
      check(host.got, exp_adv);
      check({host.gv, host.ge}, 2'b10);
      host.xfer(0, s[0], s ? 12'(EPA_LP_INDEX) : EPA_LP_OFFSET, 0);
      check(host.got, 32'h4000 | (exp_adv & 32'hfff));
    end
    check(32'(adv), {21'h0, exp_adv[11:10], exp_adv[8:0]});
  endtask
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic do_reset(input logic s);
    @(posedge sys_clk_i);
    strap <= s;
    sys_rst_i <= 1;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    exp_adv = s ? 32'h1e1 : 32'h5e1;
  endtask
  task automatic wr_adv(input logic [31:0] d);
    host.xfer(1, 0, EPA_ADV_OFFSET, d);
    check(host.ge, 0);
    exp_adv = d & 32'h0dff;
    rd_both();
  endtask
  initial begin
    do_reset(0);
    rd_both();
    $display("test defaults done");
    wr_adv(32'hffffffe1);
    // selector kept at the only legal code
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      wr_adv({~lfsr, lfsr[15:5], EPA_SELECTOR_RST});
    end
    $display("test writes done");
    host.xfer(1, 0, EPA_LP_OFFSET, 32'h0);
    check(host.ge, 0);
    host.xfer(1, 1, 12'(EPA_LP_INDEX), 32'h0);
    check(host.ge, 0);
    rd_both();
    host.xfer(1, 1, 12'(EPA_ADV_INDEX), 32'h0001_0561);
    check(host.ge, 0);
    exp_adv = 32'h0000_0561;
    rd_both();
    host.xfer(0, 0, 12'h1d8, 0);
    check(host.got, 0);
    check({host.gv, host.ge}, 2'b11);
    $display("test refusals done");
    @(posedge sys_clk_i);
    reload <= 1;
    @(posedge sys_clk_i);
    reload <= 0;
    exp_adv = 32'h5e1;
    rd_both();
    $display("test reload done");
    do_reset(1);
    rd_both();
    $display("test strap high done");
    tally_and_finish();
  end
  initial begin
    #200us;
    bad_count++;
    tally_and_finish();
  end
endmodule
